// >>> common/flash_status_pkg.sv
// constants and types for the flash status and protection registers
package flash_status_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ      = 50;
  localparam int NV_WRITE_NS  = 10000;  // non-volatile status write time
  localparam int NV_WRITE_CYC = (NV_WRITE_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W        = 13;

  // ------------------------------------------------------------
  // serial command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE_EN    = 8'h06;
  localparam logic [7:0] CMD_WRITE_DIS   = 8'h04;
  localparam logic [7:0] CMD_VOL_WRITE_EN = 8'h50;
  localparam logic [7:0] CMD_WR_STAT_ONE = 8'h01;
  localparam logic [7:0] CMD_WR_STAT_TWO = 8'h31;
  localparam logic [7:0] CMD_WR_STAT_THR = 8'h11;
  localparam logic [7:0] CMD_RD_STAT_ONE = 8'h05;
  localparam logic [7:0] CMD_RD_STAT_TWO = 8'h35;
  localparam logic [7:0] CMD_RD_STAT_THR = 8'h15;
  localparam logic [7:0] CMD_PAGE_PROG   = 8'h02;
  localparam logic [7:0] CMD_SECT_ERASE  = 8'h20;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] CMD_CHIP_ERASE  = 8'hC7;
  localparam logic [7:0] CMD_SUSPEND     = 8'h75;
  localparam logic [7:0] CMD_RESUME      = 8'h7A;
  localparam logic [7:0] CMD_SOFT_RESET  = 8'h99;

  // ------------------------------------------------------------
  // field positions within the status bytes
  // ------------------------------------------------------------
  localparam int B1_GUARD = 7;
  localparam int B1_SMALL = 6;
  localparam int B1_ANCHOR = 5;
  localparam int B1_RANGE_HI = 4;
  localparam int B1_RANGE_LO = 2;
  localparam int B2_INVERT = 6;
  localparam int B2_LOCK_HI = 5;
  localparam int B2_LOCK_LO = 3;
  localparam int B2_QUAD = 1;
  localparam int B3_ROLE = 7;
  localparam int B3_DRV_HI = 6;
  localparam int B3_DRV_LO = 5;
  localparam int B3_HFM = 4;

  // ------------------------------------------------------------
  // configuration copies and output bundles
  // ------------------------------------------------------------
  typedef struct packed {
    logic       status_guard_bit;
    logic       small_unit_select;
    logic       range_anchor_select;
    logic [2:0] protect_range;
    logic       invert_protect_map;
    logic       quad_io_enable;
    logic       pin_role_select;
    logic       high_speed_select;
  } cfg_t;

  localparam cfg_t CFG_RESET = '0;
  localparam logic [1:0] DRV_RESET = 2'h0;
  localparam logic [2:0] LOCK_RESET = 3'h0;

  typedef struct packed {
    logic       small_unit_select;
    logic       range_anchor_select;
    logic [2:0] protect_range;
    logic       invert_protect_map;
  } protect_out_t;

  typedef struct packed {
    logic       pause_fn_en;
    logic       clear_fn_en;
    logic       quad_io_enable;
    logic [1:0] output_strength;
    logic       high_speed_select;
  } pin_out_t;

endpackage

// >>> hw/flash_status_protect_regs.sv
// status, protection and configuration registers of a serial nor flash
`timescale 1ns/10ps

module flash_status_protect_regs
  import flash_status_pkg::*;
(
  input  wire logic         mclk,          // system clock, 50 MHz
  input  wire logic         resetn,        // synchronous reset, low
  input  wire logic         spi_sclk,      // serial clock pin
  input  wire logic         spi_cs_n,      // chip select pin, low
  input  wire logic         spi_si,        // serial data in pin
  input  wire logic         wp_n,          // write-protect pin, low
  input  wire logic         array_done,    // array engine finished
  output logic              spi_so,        // serial data out
  output logic              spi_so_oe,     // serial data out enable
  output logic              array_start,   // array operation start pulse
  output logic [7:0]        array_cmd,     // command given to array
  output logic              busy_out,      // embedded operation running
  output protect_out_t      protect_out,   // active protection setup
  output pin_out_t          pin_out,       // pin roles and drive
  output logic [2:0]        lock_out       // security page locks
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
  logic cs_s1_r, cs_s2_r, cs_s3_r;
  logic si_s1_r, si_s2_r, wp_s1_r, wp_s2_r;

  // two flops per pin, a third only for edge finding
  always_ff @(posedge mclk) begin
    sclk_s1_r <= spi_sclk;
    sclk_s2_r <= sclk_s1_r;
    sclk_s3_r <= sclk_s2_r;
    cs_s1_r   <= spi_cs_n;
    cs_s2_r   <= cs_s1_r;
    cs_s3_r   <= cs_s2_r;
    si_s1_r   <= spi_si;
    si_s2_r   <= si_s1_r;
    wp_s1_r   <= wp_n;
    wp_s2_r   <= wp_s1_r;
  end

  wire sclk_rise = sclk_s2_r & ~sclk_s3_r & ~cs_s2_r;
  wire sclk_fall = ~sclk_s2_r & sclk_s3_r & ~cs_s2_r;
  wire cs_rise   = cs_s2_r & ~cs_s3_r;

  // ------------------------------------------------------------
  // serial byte collection
  // ------------------------------------------------------------
  logic [2:0] bit_cnt_r;
  logic [1:0] byte_idx_r;
  logic [7:0] shift_r, cmd_r, dat1_r, dat2_r, tx_r;

  wire [7:0] rx_byte  = {shift_r[6:0], si_s2_r};
  wire       byte_end = sclk_rise & (bit_cnt_r == 3'h7);
  wire [2:0] bit_cnt_nxt  = cs_s2_r ? 3'h0 :
                            sclk_rise ? bit_cnt_r + 3'h1 : bit_cnt_r;
  wire [1:0] byte_idx_nxt = cs_s2_r ? 2'h0 :
                            (byte_end & (byte_idx_r != 2'h3)) ?
                            byte_idx_r + 2'h1 : byte_idx_r;

  // counters clear while deselected
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      bit_cnt_r  <= 3'h0;
      byte_idx_r <= 2'h0;
      shift_r    <= 8'h00;
      cmd_r      <= 8'h00;
      dat1_r     <= 8'h00;
      dat2_r     <= 8'h00;
    end else begin
      bit_cnt_r  <= bit_cnt_nxt;
      byte_idx_r <= byte_idx_nxt;
      if (sclk_rise) shift_r <= rx_byte;
      if (byte_end && byte_idx_r == 2'h0) cmd_r <= rx_byte;
      if (byte_end && byte_idx_r == 2'h1) dat1_r <= rx_byte;
      if (byte_end && byte_idx_r == 2'h2) dat2_r <= rx_byte;
    end
  end

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  cfg_t             cfg_nv_r, cfg_v_r;
  logic [1:0]       drv_r;
  logic [2:0]       lock_r;
  logic             busy_r, busy_nv_r, wel_r, vol_wen_r, paused_r;
  logic [TMR_W-1:0] tmr_r;

  // status bytes as read back
  wire [7:0] stat_one = {cfg_v_r.status_guard_bit, cfg_v_r.small_unit_select,
                         cfg_v_r.range_anchor_select, cfg_v_r.protect_range,
                         wel_r, busy_r};
  wire [7:0] stat_two = {paused_r, cfg_v_r.invert_protect_map, lock_r,
                         1'b0, cfg_v_r.quad_io_enable, 1'b0};
  wire [7:0] stat_thr = {cfg_v_r.pin_role_select, drv_r,
                         cfg_v_r.high_speed_select, 4'h0};

  // ------------------------------------------------------------
  // command decode at chip-select release
  // ------------------------------------------------------------
  wire exec    = cs_rise & (bit_cnt_r == 3'h0) & (byte_idx_r != 2'h0);
  wire accept  = exec & ~busy_r;
  wire c_wren  = accept & (cmd_r == CMD_WRITE_EN);
  wire c_wrdi  = accept & (cmd_r == CMD_WRITE_DIS);
  wire c_vwen  = accept & (cmd_r == CMD_VOL_WRITE_EN);
  wire c_sus   = accept & (cmd_r == CMD_SUSPEND);
  wire c_res   = accept & (cmd_r == CMD_RESUME);
  wire c_srst  = accept & (cmd_r == CMD_SOFT_RESET);
  wire c_ws1   = accept & (cmd_r == CMD_WR_STAT_ONE) & (byte_idx_r >= 2'h2);
  wire c_ws2   = accept & (cmd_r == CMD_WR_STAT_TWO) & (byte_idx_r >= 2'h2);
  wire c_ws3   = accept & (cmd_r == CMD_WR_STAT_THR) & (byte_idx_r >= 2'h2);
  wire c_wstat = c_ws1 | c_ws2 | c_ws3;
  wire c_arr   = accept & ((cmd_r == CMD_PAGE_PROG) |
                 (cmd_r == CMD_SECT_ERASE) | (cmd_r == CMD_BLOCK_ERASE) |
                 (cmd_r == CMD_CHIP_ERASE));

  // write-protect pin counts only with guard set and quad off
  wire hw_locked = cfg_v_r.status_guard_bit & ~wp_s2_r &
                   ~cfg_v_r.quad_io_enable;
  // a locked write to bytes one or two leaves both copies and the locks unchanged
  wire w_block   = (c_ws1 | c_ws2) & hw_locked;
  wire wr_nv     = c_wstat & wel_r & ~w_block;
  wire wr_vol    = c_wstat & ~wel_r & vol_wen_r & ~w_block;
  wire wr_go     = wr_nv | wr_vol;
  wire w_one     = c_ws1 & ~hw_locked;
  wire w_two     = (c_ws2 | (c_ws1 & (byte_idx_r == 2'h3))) & ~hw_locked;
  wire w_thr     = c_ws3;
  wire [7:0] b2  = c_ws1 ? dat2_r : dat1_r;

  // merged image: written fields replace base, flags never from data
  cfg_t base_cfg, new_cfg;
  assign base_cfg = wr_nv ? cfg_nv_r : cfg_v_r;
  assign new_cfg = '{
    status_guard_bit:    w_one ? dat1_r[B1_GUARD] : base_cfg.status_guard_bit,
    small_unit_select:   w_one ? dat1_r[B1_SMALL]
                               : base_cfg.small_unit_select,
    range_anchor_select: w_one ? dat1_r[B1_ANCHOR]
                               : base_cfg.range_anchor_select,
    protect_range:       w_one ? dat1_r[B1_RANGE_HI:B1_RANGE_LO]
                               : base_cfg.protect_range,
    invert_protect_map:  w_two ? b2[B2_INVERT]
                               : base_cfg.invert_protect_map,
    quad_io_enable:      w_two ? b2[B2_QUAD] : base_cfg.quad_io_enable,
    pin_role_select:     w_thr ? dat1_r[B3_ROLE] : base_cfg.pin_role_select,
    high_speed_select:   w_thr ? dat1_r[B3_HFM]
                               : base_cfg.high_speed_select
  };

  // non-volatile write updates both copies; volatile only the working one
  wire cfg_nv_en  = wr_nv;
  wire cfg_v_en   = wr_go | c_srst;
  wire cfg_t_nxt_sel = c_srst;
  cfg_t cfg_v_nxt;
  assign cfg_v_nxt = cfg_t_nxt_sel ? cfg_nv_r : new_cfg;

  // lock bits only ever gain ones, and only by a non-volatile write
  wire [2:0] lock_nxt = (wr_nv & w_two) ?
                        (lock_r | b2[B2_LOCK_HI:B2_LOCK_LO]) : lock_r;

  // ------------------------------------------------------------
  // flag next values
  // ------------------------------------------------------------
  wire busy_done = busy_r & (busy_nv_r ? (tmr_r == '0) : array_done);
  wire busy_set  = (c_arr & wel_r) | wr_nv;
  wire busy_nxt  = busy_set | (busy_r & ~busy_done);
  wire wel_nxt   = c_wren | (wel_r & ~(c_wrdi | c_wstat | c_arr |
                                       c_srst));
  wire vwen_nxt  = accept ? (cmd_r == CMD_VOL_WRITE_EN) : vol_wen_r;
  wire pause_nxt = c_sus | (paused_r & ~c_res);
  wire [TMR_W-1:0] tmr_nxt = wr_nv ? TMR_W'(NV_WRITE_CYC - 1) :
                  (tmr_r != '0) ? tmr_r - TMR_W'(1) : tmr_r;

  // configuration copies, cleared at power-up as a matched pair
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg_nv_r <= CFG_RESET;
      cfg_v_r  <= CFG_RESET;
      drv_r    <= DRV_RESET;
      lock_r   <= LOCK_RESET;
    end else begin
      if (cfg_nv_en) cfg_nv_r <= new_cfg;
      if (cfg_v_en) cfg_v_r <= cfg_v_nxt;
      if (wr_vol & w_thr) drv_r <= dat1_r[B3_DRV_HI:B3_DRV_LO];
      lock_r <= lock_nxt;
    end
  end

  // status flags, written only from their own causes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy_r    <= 1'b0;
      busy_nv_r <= 1'b0;
      wel_r     <= 1'b0;
      vol_wen_r <= 1'b0;
      paused_r  <= 1'b0;
      tmr_r     <= '0;
    end else begin
      busy_r    <= busy_nxt;
      if (busy_set) busy_nv_r <= wr_nv;
      wel_r     <= wel_nxt;
      vol_wen_r <= vwen_nxt;
      paused_r  <= pause_nxt;
      tmr_r     <= tmr_nxt;
    end
  end

  // ------------------------------------------------------------
  // status read-back shifter
  // ------------------------------------------------------------
  wire is_rd = (cmd_r == CMD_RD_STAT_ONE) | (cmd_r == CMD_RD_STAT_TWO) |
               (cmd_r == CMD_RD_STAT_THR);
  wire [7:0] rd_cmd = (byte_idx_r == 2'h0) ? rx_byte : cmd_r;
  wire [7:0] rd_sel = (rd_cmd == CMD_RD_STAT_ONE) ? stat_one :
                      (rd_cmd == CMD_RD_STAT_TWO) ? stat_two : stat_thr;
  wire rd_load = byte_end & ((byte_idx_r == 2'h0) ?
                 ((rx_byte == CMD_RD_STAT_ONE) | (rx_byte == CMD_RD_STAT_TWO) |
                  (rx_byte == CMD_RD_STAT_THR)) : is_rd);
  wire rd_act  = ~cs_s2_r & (byte_idx_r != 2'h0) & is_rd;

  // fresh byte at each boundary, msb leaves on the next falling edge
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tx_r      <= 8'h00;
      spi_so    <= 1'b0;
      spi_so_oe <= 1'b0;
    end else begin
      if (rd_load) tx_r <= rd_sel;
      else if (sclk_fall && rd_act) tx_r <= {tx_r[6:0], 1'b0};
      if (sclk_fall && rd_act) spi_so <= tx_r[7];
      spi_so_oe <= rd_act;
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  wire pin_gate = ~cfg_v_r.quad_io_enable;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      array_start <= 1'b0;
      array_cmd   <= 8'h00;
      busy_out    <= 1'b0;
      protect_out <= '0;
      pin_out     <= '0;
      lock_out    <= LOCK_RESET;
    end else begin
      array_start <= c_arr & wel_r;
      if (c_arr & wel_r) array_cmd <= cmd_r;
      busy_out    <= busy_r;
      protect_out <= '{cfg_v_r.small_unit_select, cfg_v_r.range_anchor_select,
                       cfg_v_r.protect_range, cfg_v_r.invert_protect_map};
      pin_out.pause_fn_en <= pin_gate & ~cfg_v_r.pin_role_select;
      pin_out.clear_fn_en <= pin_gate & cfg_v_r.pin_role_select;
      pin_out.quad_io_enable    <= cfg_v_r.quad_io_enable;
      pin_out.output_strength   <= drv_r;
      pin_out.high_speed_select <= cfg_v_r.high_speed_select;
      lock_out    <= lock_r;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_ROLE_CLEAR: assert property (
    @(posedge mclk) disable iff (!resetn)
    !cfg_v_r.quad_io_enable && cfg_v_r.pin_role_select
      |=> pin_out.clear_fn_en && !pin_out.pause_fn_en)
    else $error("pin role clear not applied");
  AST_QUAD_GATES: assert property (
    @(posedge mclk) disable iff (!resetn)
    pin_out.quad_io_enable |-> !pin_out.pause_fn_en && !pin_out.clear_fn_en)
    else $error("pin role active with quad on");
  AST_DRIVE: assert property (
    @(posedge mclk) disable iff (!resetn)
    wr_vol && w_thr |=> ##1
      pin_out.output_strength == dat1_r[B3_DRV_HI:B3_DRV_LO])
    else $error("drive strength not applied");
  AST_BUSY_SET: assert property (
    @(posedge mclk) disable iff (!resetn)
    c_arr && wel_r |=> busy_r ##1 busy_out && array_start == 1'b0)
    else $error("busy not raised for array operation");
  AST_BUSY_HOLD: assert property (
    @(posedge mclk) disable iff (!resetn)
    busy_r && exec |=> $stable(wel_r) && $stable(cfg_v_r) && $stable(paused_r))
    else $error("command obeyed while busy");
  AST_BUSY_END: assert property (
    @(posedge mclk) disable iff (!resetn)
    busy_r && busy_nv_r |-> ##[1:600] !busy_r)
    else $error("status write busy did not end");
  AST_LATCH_SET: assert property (
    @(posedge mclk) disable iff (!resetn)
    c_wren |=> wel_r)
    else $error("write latch not set");
  AST_LATCH_CLR: assert property (
    @(posedge mclk) disable iff (!resetn)
    c_wrdi || c_wstat || c_arr |=> !wel_r)
    else $error("write latch not cleared");
  AST_RANGE_WRITE: assert property (
    @(posedge mclk) disable iff (!resetn)
    wr_go && w_one
      |=> cfg_v_r.protect_range == dat1_r[B1_RANGE_HI:B1_RANGE_LO])
    else $error("protect range not written");
  AST_LOCKED: assert property (
    @(posedge mclk) disable iff (!resetn)
    (c_ws1 || c_ws2) && hw_locked
      |=> $stable(cfg_nv_r) && $stable(cfg_v_r) && $stable(lock_r))
    else $error("status write accepted while locked");
  AST_GUARD_OPEN: assert property (
    @(posedge mclk) disable iff (!resetn)
    wr_nv && w_one |=> cfg_nv_r.status_guard_bit == dat1_r[B1_GUARD])
    else $error("open status write not applied");
  AST_FLAGS_KEEP: assert property (
    @(posedge mclk) disable iff (!resetn)
    c_wstat |=> !wel_r && $stable(paused_r) && busy_r == $past(wr_nv))
    else $error("status write disturbed a flag");
  AST_PAUSED: assert property (
    @(posedge mclk) disable iff (!resetn)
    c_sus |=> paused_r until_with c_res)
    else $error("paused flag lost");
  AST_LOCK_KEEP: assert property (
    @(posedge mclk) disable iff (!resetn)
    ($past(lock_r) & ~lock_r) == 3'h0)
    else $error("lock bit cleared");
  AST_VOL_NO_LOCK: assert property (
    @(posedge mclk) disable iff (!resetn)
    wr_vol |=> $stable(lock_r) && $stable(cfg_nv_r))
    else $error("volatile write touched non-volatile state");
  AST_SRST_LOAD: assert property (
    @(posedge mclk) disable iff (!resetn)
    c_srst |=> cfg_v_r == cfg_nv_r)
    else $error("soft reset did not reload working copy");

endmodule

// >>> dv/spi_host_model.sv
// spi mode 0 host that issues flash commands byte by byte
`timescale 1ns/10ps

module spi_host_model (
  output logic      spi_sclk,  // serial clock, idle low
  output logic      spi_cs_n,  // chip select, low
  output logic      spi_si,    // data toward the flash
  input  wire logic spi_so     // data from the flash
);
  // ------------------------------------------------------------
  // idle levels: clock stands still outside frames
  // ------------------------------------------------------------
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_si   = 1'b0;
  end

  // open a frame at the caller's drive point after its clock edge
  task automatic select();
    spi_cs_n = 1'b0;
    #80;
  endtask

  // eight bits msb first; data changes while clock is low
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_si = tx[i];
      #80;
      rx[i] = spi_so;
      spi_sclk = 1'b1;
      #80;
      spi_sclk = 1'b0;
    end
  endtask

  // close on a byte boundary; released data line is inverted
  task automatic deselect();
    #80;
    spi_cs_n = 1'b1;
    spi_si = ~spi_si;
    #240;
  endtask
endmodule

// >>> dv/flash_status_protect_regs_tb.sv
// self-checking bench for the flash status and protection registers
`timescale 1ns/10ps

module flash_status_protect_regs_tb;
  import flash_status_pkg::*;

  logic         mclk, resetn, wp_n, array_done;
  logic         spi_sclk, spi_cs_n, spi_si, spi_so, spi_so_oe;
  logic         array_start, busy_out;
  logic [7:0]   array_cmd;
  protect_out_t protect_out;
  pin_out_t     pin_out;
  logic [2:0]   lock_out;
  int           n_mismatch, checks, n_start;
  logic [7:0]   r;
  logic [7:0]   ops [4] = '{8'h02, 8'h20, 8'hD8, 8'hC7};

  // ------------------------------------------------------------
  // design, host model, clock
  // ------------------------------------------------------------
  flash_status_protect_regs flash_status_protect_regs_inst (
    .mclk(mclk), .resetn(resetn), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_si(spi_si), .wp_n(wp_n),
    .array_done(array_done), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
    .array_start(array_start), .array_cmd(array_cmd),
    .busy_out(busy_out), .protect_out(protect_out),
    .pin_out(pin_out), .lock_out(lock_out));
  spi_host_model spi_host_model_inst (
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
    .spi_so(spi_so));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // counts array start pulses
  always @(negedge mclk) if (array_start === 1'b1) n_start++;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic go();
    @(posedge mclk);
    #2;
  endtask

  task automatic frame(input logic [7:0] op, input logic [7:0] d,
                       input bit two);
    logic [7:0] x;
    go();
    spi_host_model_inst.select();
    spi_host_model_inst.byte_io(op, x);
    if (two) spi_host_model_inst.byte_io(d, x);
    spi_host_model_inst.deselect();
    repeat (8) @(posedge mclk);
  endtask

  task automatic cmd(input logic [7:0] op);
    frame(op, 8'h00, 1'b0);
  endtask

  task automatic rd(input logic [7:0] op, output logic [7:0] v);
    logic [7:0] x;
    go();
    spi_host_model_inst.select();
    spi_host_model_inst.byte_io(op, x);
    spi_host_model_inst.byte_io(8'h00, v);
    spi_host_model_inst.byte_io(8'h00, x);
    check({7'h0, spi_so_oe}, 8'h01);
    spi_host_model_inst.deselect();
    check(x, v);
    check({7'h0, spi_so_oe}, 8'h00);
  endtask

  task automatic wait_idle();
    repeat (NV_WRITE_CYC + 20) @(posedge mclk);
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_reset();
    rd(CMD_RD_STAT_ONE, r); check(r, 8'h00);
    rd(CMD_RD_STAT_TWO, r); check(r, 8'h00);
    rd(CMD_RD_STAT_THR, r); check(r, 8'h00);
    check({2'h0, pin_out}, 8'h20);
    check({5'h0, lock_out}, 8'h00);
    $display("test_reset done");
  endtask

  task automatic test_latch();
    cmd(CMD_WRITE_EN); rd(CMD_RD_STAT_ONE, r); check(r, 8'h02);
    cmd(CMD_WRITE_DIS); rd(CMD_RD_STAT_ONE, r); check(r, 8'h00);
    $display("test_latch done");
  endtask

  task automatic test_volatile();
    cmd(CMD_VOL_WRITE_EN); frame(CMD_WR_STAT_ONE, 8'hFF, 1'b1);
    rd(CMD_RD_STAT_ONE, r); check(r, 8'hFC);
    check({2'h0, protect_out}, 8'h3E);
    cmd(CMD_VOL_WRITE_EN); frame(CMD_WR_STAT_TWO, 8'hFF, 1'b1);
    rd(CMD_RD_STAT_TWO, r); check(r, 8'h42);
    check({5'h0, lock_out}, 8'h00);
    check({2'h0, pin_out}, 8'h08);
    cmd(CMD_VOL_WRITE_EN); frame(CMD_WR_STAT_THR, 8'hF0, 1'b1);
    rd(CMD_RD_STAT_THR, r); check(r, 8'hF0);
    check({2'h0, pin_out}, 8'h0F);
    cmd(CMD_VOL_WRITE_EN); frame(CMD_WR_STAT_TWO, 8'h00, 1'b1);
    check({2'h0, pin_out}, 8'h17);
    cmd(CMD_VOL_WRITE_EN); frame(CMD_WR_STAT_THR, 8'h00, 1'b1);
    check({2'h0, pin_out}, 8'h20);
    $display("test_volatile done");
  endtask

  task automatic test_guard();
    go(); wp_n = 1'b0;
    cmd(CMD_VOL_WRITE_EN); frame(CMD_WR_STAT_ONE, 8'h00, 1'b1);
    rd(CMD_RD_STAT_ONE, r); check(r, 8'hFC);
    cmd(CMD_WRITE_EN); frame(CMD_WR_STAT_ONE, 8'h00, 1'b1);
    rd(CMD_RD_STAT_ONE, r); check(r, 8'hFC);
    go(); wp_n = 1'b1;
    cmd(CMD_WRITE_EN); frame(CMD_WR_STAT_ONE, 8'h0C, 1'b1);
    rd(CMD_RD_STAT_ONE, r); check(r, 8'h0D);
    check({7'h0, busy_out}, 8'h01);
    cmd(CMD_WRITE_EN); wait_idle();
    rd(CMD_RD_STAT_ONE, r); check(r, 8'h0C);
    check({2'h0, protect_out}, 8'h06);
    go(); wp_n = 1'b0;
    cmd(CMD_WRITE_EN); frame(CMD_WR_STAT_ONE, 8'h10, 1'b1); wait_idle();
    rd(CMD_RD_STAT_ONE, r); check(r, 8'h10);
    go(); wp_n = 1'b1;
    cmd(CMD_VOL_WRITE_EN); frame(CMD_WR_STAT_ONE, 8'h64, 1'b1);
    rd(CMD_RD_STAT_ONE, r); check(r, 8'h64);
    cmd(CMD_SOFT_RESET);
    rd(CMD_RD_STAT_ONE, r); check(r, 8'h10);
    check({2'h0, protect_out}, 8'h08);
    $display("test_guard done");
  endtask

  task automatic test_array();
    int s;
    s = n_start;
    cmd(CMD_PAGE_PROG); repeat (4) @(posedge mclk);
    check(8'(n_start - s), 8'h00);
    foreach (ops[i]) begin
      s = n_start;
      cmd(CMD_WRITE_EN); cmd(ops[i]);
      check(8'(n_start - s), 8'h01);
      check(array_cmd, ops[i]);
      rd(CMD_RD_STAT_ONE, r); check(r, 8'h11);
      go(); array_done = 1'b1;
      go(); array_done = 1'b0;
      repeat (4) @(posedge mclk);
      rd(CMD_RD_STAT_ONE, r); check(r, 8'h10);
    end
    $display("test_array done");
  endtask

  task automatic test_suspend();
    cmd(CMD_SUSPEND); rd(CMD_RD_STAT_TWO, r); check(r, 8'h80);
    cmd(CMD_RESUME); rd(CMD_RD_STAT_TWO, r); check(r, 8'h00);
    $display("test_suspend done");
  endtask

  task automatic test_locks();
    cmd(CMD_WRITE_EN); frame(CMD_WR_STAT_TWO, 8'h08, 1'b1); wait_idle();
    check({5'h0, lock_out}, 8'h01);
    cmd(CMD_WRITE_EN); frame(CMD_WR_STAT_TWO, 8'h20, 1'b1); wait_idle();
    check({5'h0, lock_out}, 8'h05);
    cmd(CMD_WRITE_EN); frame(CMD_WR_STAT_TWO, 8'h00, 1'b1); wait_idle();
    check({5'h0, lock_out}, 8'h05);
    rd(CMD_RD_STAT_TWO, r); check(r, 8'h28);
    $display("test_locks done");
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    resetn = 1'b0; wp_n = 1'b1; array_done = 1'b0;
    n_mismatch = 0; checks = 0; n_start = 0;
    repeat (5) @(posedge mclk);
    go(); resetn = 1'b1;
    repeat (3) @(posedge mclk);
    test_reset(); test_latch(); test_volatile(); test_guard();
    test_array(); test_suspend(); test_locks();
    test_done();
  end

  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    test_done();
  end
endmodule
